// File: hdl/cond_pkg.sv
// Purpose: Shared constants and types of the condition output unit.
// Assumes: Bit operands are addressed as word in [15:4], bit in [3:0].
// Notes:   Every number used by more than one file lives here.
package cond_pkg;

  // Width of a bit operand address.
  localparam int unsigned ADDR_W = 16;
  // Number of temporary condition bits.
  localparam int unsigned TEMP_COUNT = 16;
  // Number of edge conditioning instances that keep a stored condition.
  localparam int unsigned EDGE_SLOTS = 16;
  // Width of an index into either condition bank.
  localparam int unsigned IDX_W = 4;
  // Width of the condition flag register.
  localparam int unsigned FLAG_W = 4;
  // Position of the instruction error flag.
  localparam int unsigned FLAG_ERR_POS = 0;
  // Reset value of the condition flag register.
  localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
  // Word address of the built-in output terminals.
  localparam logic [11:0] TERM_WORD = 12'h064;
  // Reset value of the built-in output terminals.
  localparam logic [15:0] TERM_RST = 16'h0000;
  // Function codes of the condition instructions, kept for reference.
  localparam logic [9:0] FC_INVERT = 10'h208;
  localparam logic [9:0] FC_RISE   = 10'h209;
  localparam logic [9:0] FC_FALL   = 10'h20A;

  // Instructions accepted by the unit.
  typedef enum logic [3:0] {
    OP_NOP     = 4'h0,
    OP_LD      = 4'h1,
    OP_LD_NOT  = 4'h2,
    OP_AND     = 4'h3,
    OP_OR      = 4'h4,
    OP_INVERT  = 4'h5,
    OP_RISE    = 4'h6,
    OP_FALL    = 4'h7,
    OP_OUT     = 4'h8,
    OP_OUT_NOT = 4'h9,
    OP_SET     = 4'hA,
    OP_CLR     = 4'hB
  } op_t;

  // Execution state of the program section holding the instruction.
  typedef enum logic [1:0] {
    SECT_RUN  = 2'h0,
    SECT_LOCK = 2'h1,
    SECT_SKIP = 2'h3
  } sect_t;

endpackage

// File: hdl/cond_bank_if.sv
// Purpose: Carries one read and write port of a bank of condition bits.
// Assumes: Read data is combinational from the index.
// Notes:   The owner holds the bits, the user steers them.
`timescale 1ns/1ps
`default_nettype none
interface cond_bank_if;
  import cond_pkg::*;
  logic [IDX_W-1:0] idx;   // Selected bit.
  logic             we;    // Write strobe for the selected bit.
  logic             wdata; // Value written.
  logic             rdata; // Value currently stored.
  modport owner (input idx, input we, input wdata, output rdata);
  modport user  (output idx, output we, output wdata, input rdata);
endinterface
`default_nettype wire

// File: hdl/temp_bank.sv
// Purpose: Holds the temporary condition bits used to branch a rung.
// Assumes: At most one write per clock.
// Notes:   Any bit may be used in any order; no ordering is enforced.
`timescale 1ns/1ps
`default_nettype none
module temp_bank
  import cond_pkg::*;
(
  input  wire logic sys_clk, // System clock.
  input  wire logic rst_sb,  // Synchronised reset, active low.
  cond_bank_if.owner bank    // Save and restore port.
);

  // Storage for the temporary condition bits.
  logic [TEMP_COUNT-1:0] temp_condition_bit_q;

  // Reads are direct so a restore sees the bit in the same cycle.
  assign bank.rdata = temp_condition_bit_q[bank.idx];

  // Saving writes only the addressed bit; the others keep their state.
  always_ff @(posedge sys_clk or negedge rst_sb) begin
    if (!rst_sb) begin
      temp_condition_bit_q <= '0;
    end else if (bank.we) begin
      temp_condition_bit_q[bank.idx] <= bank.wdata;
    end
  end

endmodule
`default_nettype wire

// File: hdl/edge_store.sv
// Purpose: Remembers the input condition of each edge instruction instance.
// Assumes: Each instance in the program owns a distinct slot number.
// Notes:   A slot is only updated when its instance is evaluated.
`timescale 1ns/1ps
`default_nettype none
module edge_store
  import cond_pkg::*;
(
  input  wire logic sys_clk, // System clock.
  input  wire logic rst_sb,  // Synchronised reset, active low.
  cond_bank_if.owner bank,   // Slot select, new condition and old condition.
  output logic      rise,    // New condition true, previous false.
  output logic      fall     // New condition false, previous true.
);

  // Previous input condition of every instance.
  logic [EDGE_SLOTS-1:0] prev_q;

  // The stored copy of the selected instance.
  assign bank.rdata = prev_q[bank.idx];
  // Transitions compare the offered condition with that copy.
  assign rise = bank.wdata & ~bank.rdata;
  assign fall = ~bank.wdata & bank.rdata;

  // Each evaluation replaces the copy of its own instance only.
  always_ff @(posedge sys_clk or negedge rst_sb) begin
    if (!rst_sb) begin
      prev_q <= '0;
    end else if (bank.we) begin
      prev_q[bank.idx] <= bank.wdata;
    end
  end

endmodule
`default_nettype wire

// File: hdl/cond_out_unit.sv
// Purpose: Executes condition inversion, edge conditioning, bit outputs
//          and temporary condition bits, one instruction per clock.
// Assumes: The instruction port is driven by logic on sys_clk.
// Notes:   The running condition is held in cond_q between instructions.
//
// Overview of operation
// - Invert instruction complements the running condition.
// - These instructions leave all condition flags unchanged.
// - Rising conditioning passes true one scan only.
// - Falling conditioning passes true one scan only.
// - Edge detection also follows section execution state.
// - Skipped subroutine evaluates no edge instruction.
// - Output writes running condition every execution, false in an interlocked section.
// - Inverted output writes complemented condition every execution, true in an interlocked section.
// - Immediate refresh also drives built-in output terminal.
// - Set and clear write only while condition true.
// - Sixteen temporary bits save and restore conditions.
// - Temporary bits only with plain load (not inverted load) and output.
// - Temporary bits usable in any numerical order.
`timescale 1ns/1ps
`default_nettype none
module cond_out_unit
  import cond_pkg::*;
(
  input  wire logic              sys_clk,      // System clock, 10 MHz.
  input  wire logic              rst_b,        // Asynchronous reset, active low.
  input  wire logic              instr_valid,  // An instruction is offered this cycle.
  input  wire op_t               instr_op,     // Instruction to execute.
  input  wire logic              instr_temp,   // Operand names a temporary bit.
  input  wire logic              instr_imm,    // Immediate refresh requested.
  input  wire logic [ADDR_W-1:0] instr_addr,   // Bit operand address or temp index.
  input  wire logic [IDX_W-1:0]  instr_slot,   // Edge instance number.
  input  wire sect_t             section_mode, // State of the enclosing section.
  input  wire logic              io_rd_bit,    // Addressed core_io_area bit for loads.
  input  wire logic              flag_clr,     // Clears the error flag.
  output logic                   cond_q,       // Running execution condition.
  output logic                   io_we_q,      // Write strobe into I/O memory.
  output logic [ADDR_W-1:0]      io_addr_q,    // Address of the written bit.
  output logic                   io_bit_q,     // Value of the written bit.
  output logic [15:0]            term_q,       // Built-in output terminals.
  output logic [FLAG_W-1:0]      flags_q,      // Condition flags.
  output logic                   reject_q      // Pulse: instruction refused.
);

  // Reset release synchroniser; only the second stage is used.
  logic rst_m_q;
  logic rst_sb;

  // The reset takes effect at once and is released on the clock.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_sb  <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_sb  <= rst_m_q;
    end
  end

  // Ports to the temporary bits and to the edge instance memory.
  cond_bank_if temp_port ();
  cond_bank_if edge_port ();
  logic edge_rise; // Rising transition of the selected instance.
  logic edge_fall; // Falling transition of the selected instance.

  temp_bank u_temp (
    .sys_clk (sys_clk),
    .rst_sb  (rst_sb),
    .bank    (temp_port)
  );

  edge_store u_edge (
    .sys_clk (sys_clk),
    .rst_sb  (rst_sb),
    .bank    (edge_port),
    .rise    (edge_rise),
    .fall    (edge_fall)
  );

  // Instruction class decode.
  wire is_load  = (instr_op == OP_LD) || (instr_op == OP_LD_NOT);
  wire is_out   = (instr_op == OP_OUT);
  wire is_outn  = (instr_op == OP_OUT_NOT);
  wire is_edge  = (instr_op == OP_RISE) || (instr_op == OP_FALL);
  wire is_setc  = (instr_op == OP_SET) || (instr_op == OP_CLR);
  // Only plain load (OP_LD, not OP_LD_NOT) and output may name a temporary bit.
  wire temp_bad = instr_temp && !(instr_op == OP_LD || is_out || is_outn);
  // A skipped section executes nothing at all.
  wire skipped  = (section_mode == SECT_SKIP);
  // An interlocked section runs its instructions with power flow off.
  wire locked   = (section_mode == SECT_LOCK);
  wire act      = instr_valid && !skipped && !temp_bad;
  wire refuse   = instr_valid && !skipped && temp_bad;
  // Condition seen by consuming instructions in this section.
  wire eff_cond = cond_q && !locked;
  // Source bit of a load: temporary bank or I/O memory.
  wire src_bit  = instr_temp ? temp_port.rdata : io_rd_bit;
  // Value an output instruction stores.
  wire out_val  = is_outn ? !eff_cond : eff_cond;
  // Set and clear drive only under a true condition.
  wire setc_go  = is_setc && eff_cond;
  // Writes into I/O memory and into the temporary bank.
  wire io_wr    = act && !instr_temp && (is_out || is_outn || setc_go);
  wire io_val   = is_setc ? (instr_op == OP_SET) : out_val;
  wire temp_wr  = act && instr_temp && (is_out || is_outn);
  // Immediate refresh of a built-in terminal bit.
  wire term_hit = io_wr && instr_imm && (is_out || is_outn)
                  && (instr_addr[15:4] == TERM_WORD);

  // Temporary bank is indexed by the operand's low bits.
  assign temp_port.idx   = instr_addr[IDX_W-1:0];
  assign temp_port.we    = temp_wr;
  assign temp_port.wdata = out_val;
  // Edge memory sees only evaluated edge instructions.
  assign edge_port.idx   = instr_slot;
  assign edge_port.we    = act && is_edge;
  assign edge_port.wdata = eff_cond;

  // Next running condition.
  logic cond_d;

  // Selects the condition passed to the following instruction.
  always_comb begin
    cond_d = cond_q;
    if (act) begin
      unique case (instr_op)
        OP_LD:      cond_d = src_bit;
        OP_LD_NOT:  cond_d = !src_bit;
        OP_AND:     cond_d = cond_q && src_bit;
        OP_OR:      cond_d = cond_q || src_bit;
        OP_INVERT:  cond_d = !cond_q;
        OP_RISE:    cond_d = edge_rise;
        OP_FALL:    cond_d = edge_fall;
        OP_NOP, OP_OUT, OP_OUT_NOT, OP_SET, OP_CLR: cond_d = cond_q;
        default:    cond_d = cond_q;
      endcase
    end
  end

  // Running condition register.
  always_ff @(posedge sys_clk or negedge rst_sb) begin
    if (!rst_sb) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond_d;
    end
  end

  // I/O memory write port; held steady between writes.
  always_ff @(posedge sys_clk or negedge rst_sb) begin
    if (!rst_sb) begin
      io_we_q   <= 1'b0;
      io_addr_q <= '0;
      io_bit_q  <= 1'b0;
    end else begin
      io_we_q <= io_wr;
      if (io_wr) begin
        io_addr_q <= instr_addr;
        io_bit_q  <= io_val;
      end
    end
  end

  // Built-in terminals follow an immediate output right after it.
  always_ff @(posedge sys_clk or negedge rst_sb) begin
    if (!rst_sb) begin
      term_q <= TERM_RST;
    end else if (term_hit) begin
      term_q[instr_addr[3:0]] <= out_val;
    end
  end

  // Error flag is set by a refusal only; set wins over a clear.
  always_ff @(posedge sys_clk or negedge rst_sb) begin
    if (!rst_sb) begin
      flags_q  <= FLAGS_RST;
      reject_q <= 1'b0;
    end else begin
      reject_q <= refuse;
      if (refuse) begin
        flags_q[FLAG_ERR_POS] <= 1'b1;
      end else if (flag_clr) begin
        flags_q[FLAG_ERR_POS] <= 1'b0;
      end
    end
  end

  // Checks of the behaviour above.
  chk_invert_cond: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && instr_op == OP_INVERT |=> cond_q == !$past(cond_q))
    else $error("invert did not complement the condition");

  chk_flags_kept: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && !flag_clr && (is_out || is_outn || is_edge || instr_op == OP_INVERT)
    |=> $stable(flags_q))
    else $error("condition flags changed");

  chk_rise_once: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && instr_op == OP_RISE
    |=> cond_q == ($past(eff_cond) && !$past(edge_port.rdata)))
    else $error("rising conditioning result wrong");

  chk_fall_once: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && instr_op == OP_FALL
    |=> cond_q == (!$past(eff_cond) && $past(edge_port.rdata)))
    else $error("falling conditioning result wrong");

  chk_lock_no_rise: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && locked && instr_op == OP_RISE |=> !cond_q)
    else $error("rising edge seen in interlocked section");

  chk_skip_inert: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    instr_valid && skipped |=> $stable(cond_q) && !io_we_q && !reject_q)
    else $error("skipped section had an effect");

  chk_out_write: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && is_out && !instr_temp
    |=> io_we_q && io_bit_q == $past(eff_cond) && io_addr_q == $past(instr_addr))
    else $error("output did not write the condition");

  chk_outn_write: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && is_outn && !instr_temp |=> io_we_q && io_bit_q == !$past(eff_cond))
    else $error("inverted output did not write the complement");

  chk_term_refresh: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    term_hit |=> term_q[$past(instr_addr[3:0])] == io_bit_q)
    else $error("terminal not refreshed with written value");

  chk_setc_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && is_setc && !eff_cond |=> !io_we_q)
    else $error("set or clear wrote under a false condition");

  chk_temp_restore: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    temp_wr ##1 (act && instr_op == OP_LD && instr_temp
                 && instr_addr[IDX_W-1:0] == $past(instr_addr[IDX_W-1:0]))
    |=> cond_q == $past(out_val, 2))
    else $error("temporary bit did not restore saved condition");

  chk_temp_refuse: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    refuse |=> reject_q && !io_we_q && flags_q[FLAG_ERR_POS] && $stable(cond_q))
    else $error("illegal temporary bit use not refused");

  // Checks of loaded and stored values, and that each path stays quiet when its cause is absent.
  chk_temp_load: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && is_load && instr_temp |=> cond_q == $past(temp_port.rdata))
    else $error("load of a temporary bit returned the wrong value");

  chk_temp_no_io: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    temp_wr |=> !io_we_q)
    else $error("temporary bit save also wrote I/O memory");

  chk_slot_skip: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    instr_valid && skipped && is_edge |=> $stable(u_edge.prev_q))
    else $error("skipped edge instruction changed its stored condition");

  chk_slot_own: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    edge_port.we |=> u_edge.prev_q[$past(edge_port.idx)] == $past(edge_port.wdata))
    else $error("edge instance did not store its input condition");

  chk_lock_out_off: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && locked && (is_out || is_outn) && !instr_temp |=> io_bit_q == $past(is_outn))
    else $error("output in interlocked section ignored the interlock");

  chk_out_keeps_cond: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    act && (is_out || is_outn || is_setc) |=> $stable(cond_q))
    else $error("output instruction altered the running condition");

  chk_write_cause: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    !io_wr |=> !io_we_q)
    else $error("I/O write strobe without a writing instruction");

  chk_term_quiet: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    !term_hit |=> $stable(term_q))
    else $error("terminals changed without an immediate output");

  chk_reject_pulse: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    !refuse |=> !reject_q)
    else $error("refusal pulse without a refused instruction");

  chk_flag_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_sb)
    !refuse && !flag_clr |=> $stable(flags_q))
    else $error("condition flags changed with no cause");

endmodule
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the condition output unit.
// Assumes: One instruction per clock, outputs visible one clock after offer.
// Notes:   Ordinary cases live in a row table; reset and refusals follow it.
`timescale 1ns/1ps
`default_nettype none
module tb
  import cond_pkg::*;
;
  // One table row: instruction, section state, loaded bit and expectation.
  // The expectation packs {check cond, cond, check write, write, bit}.
  typedef struct packed {
    op_t         op;
    logic        tmp;
    logic [15:0] adr;
    logic [3:0]  slt;
    sect_t       md;
    logic        rd;
    logic [4:0]  ex;
  } row_t;

  logic              sys_clk;      // Bench clock, 100 ns period.
  logic              rst_b;        // Reset, active low.
  logic              instr_valid;  // Instruction offered.
  op_t               instr_op;     // Instruction code.
  logic              instr_temp;   // Operand is a temporary bit.
  logic              instr_imm;    // Immediate refresh.
  logic [ADDR_W-1:0] instr_addr;   // Operand address.
  logic [IDX_W-1:0]  instr_slot;   // Edge instance number.
  sect_t             section_mode; // Enclosing section state.
  logic              io_rd_bit;    // Bit seen by loads.
  logic              flag_clr;     // Clears the error flag.
  logic              cond_q;       // Running condition.
  logic              io_we_q;      // Write pulse.
  logic [ADDR_W-1:0] io_addr_q;    // Written address.
  logic              io_bit_q;     // Written value.
  logic [15:0]       term_q;       // Built-in terminals.
  logic [FLAG_W-1:0] flags_q;      // Condition flags.
  logic              reject_q;     // Refusal pulse.
  int                num_errors;   // Mismatches seen.
  int                num_checks;   // Comparisons made.
  row_t              r;            // Row under test.
  op_t               bad_ops [5];  // Operations refused on temporary bits.

  // Each edge slot below serves one instance, evaluated once per scan.
  // Every rung ends in an output, set, clear, load or edge instruction, never in an inversion.
  row_t rows [44] = '{
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_INVERT,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_INVERT,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h1C},
    '{OP_OUT,1'h0,16'h0100,4'h0,SECT_RUN,1'h0,5'h1F},
    '{OP_OUT_NOT,1'h0,16'h0101,4'h0,SECT_RUN,1'h0,5'h1E},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_OUT,1'h0,16'h0102,4'h0,SECT_RUN,1'h0,5'h16},
    '{OP_OUT_NOT,1'h0,16'h0103,4'h0,SECT_RUN,1'h0,5'h17},
    '{OP_SET,1'h0,16'h0104,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_CLR,1'h0,16'h0105,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_SET,1'h0,16'h0104,4'h0,SECT_RUN,1'h0,5'h1F},
    '{OP_CLR,1'h0,16'h0105,4'h0,SECT_RUN,1'h0,5'h1E},
    '{OP_RISE,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h1C},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_RISE,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_RISE,1'h0,16'h0000,4'h2,SECT_RUN,1'h0,5'h1C},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_FALL,1'h0,16'h0000,4'h1,SECT_RUN,1'h0,5'h14},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_FALL,1'h0,16'h0000,4'h1,SECT_RUN,1'h0,5'h1C},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_OUT,1'h1,16'h0009,4'h0,SECT_RUN,1'h0,5'h18},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_OUT,1'h1,16'h0003,4'h0,SECT_RUN,1'h0,5'h10},
    '{OP_OUT_NOT,1'h1,16'h000C,4'h0,SECT_RUN,1'h0,5'h10},
    '{OP_LD,1'h1,16'h0009,4'h0,SECT_RUN,1'h0,5'h18},
    '{OP_LD,1'h1,16'h0003,4'h0,SECT_RUN,1'h1,5'h10},
    '{OP_LD,1'h1,16'h000C,4'h0,SECT_RUN,1'h0,5'h18},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_RISE,1'h0,16'h0000,4'h4,SECT_LOCK,1'h0,5'h14},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_RISE,1'h0,16'h0000,4'h4,SECT_RUN,1'h0,5'h1C},
    '{OP_OUT,1'h0,16'h0106,4'h0,SECT_LOCK,1'h0,5'h06},
    '{OP_OUT_NOT,1'h0,16'h0107,4'h0,SECT_LOCK,1'h0,5'h07},
    '{OP_SET,1'h0,16'h0104,4'h0,SECT_LOCK,1'h0,5'h04},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_RISE,1'h0,16'h0000,4'h5,SECT_RUN,1'h0,5'h1C},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h0,5'h14},
    '{OP_RISE,1'h0,16'h0000,4'h5,SECT_SKIP,1'h0,5'h14},
    '{OP_OUT,1'h0,16'h0108,4'h0,SECT_SKIP,1'h0,5'h14},
    '{OP_LD,1'h0,16'h0000,4'h0,SECT_RUN,1'h1,5'h1C},
    '{OP_RISE,1'h0,16'h0000,4'h5,SECT_RUN,1'h0,5'h14}
  };

  // The unit under test.
  cond_out_unit dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_temp(instr_temp), .instr_imm(instr_imm), .instr_addr(instr_addr),
    .instr_slot(instr_slot), .section_mode(section_mode), .io_rd_bit(io_rd_bit),
    .flag_clr(flag_clr), .cond_q(cond_q), .io_we_q(io_we_q), .io_addr_q(io_addr_q),
    .io_bit_q(io_bit_q), .term_q(term_q), .flags_q(flags_q), .reject_q(reject_q)
  );

  // Clock generator.
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Offers one instruction and returns once its result is visible.
  task automatic exec(input op_t op, input logic tmp, input logic imm, input logic [15:0] adr,
                      input logic [3:0] slt, input sect_t md, input logic rd);
    instr_valid  = 1'h1;
    instr_op     = op;
    instr_temp   = tmp;
    instr_imm    = imm;
    instr_addr   = adr;
    instr_slot   = slt;
    section_mode = md;
    io_rd_bit    = rd;
    @(posedge sys_clk);
    #10;
  endtask

  // Lets one clock pass with nothing offered.
  task automatic idle();
    instr_valid = 1'h0;
    @(posedge sys_clk);
    #10;
  endtask

  // Prints the verdict and stops the run.
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs about eighty clocks.
  initial begin
    #(100 * 2000);
    num_errors++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    num_errors = 0;
    num_checks = 0;
    bad_ops = '{OP_LD_NOT, OP_AND, OP_OR, OP_SET, OP_CLR};
    rst_b = 1'h0;
    flag_clr = 1'h0;
    instr_valid = 1'h0;
    instr_op = OP_NOP;
    instr_temp = 1'h0;
    instr_imm = 1'h0;
    instr_addr = 16'h0000;
    instr_slot = 4'h0;
    section_mode = SECT_RUN;
    io_rd_bit = 1'h0;
    repeat (3) @(posedge sys_clk);
    #10;
    chk({cond_q, io_we_q, reject_q, flags_q}, 16'h0000);
    chk(term_q, TERM_RST);
    rst_b = 1'h1;
    repeat (3) idle();
    // Table of ordinary cases.
    for (int i = 0; i < 44; i++) begin
      r = rows[i];
      exec(r.op, r.tmp, 1'h0, r.adr, r.slt, r.md, r.rd);
      if (r.ex[4]) chk(16'(cond_q), 16'(r.ex[3]));
      if (r.ex[2]) chk(16'(io_we_q), 16'(r.ex[1]));
      if (r.ex[1]) chk(16'(io_bit_q), 16'(r.ex[0]));
      if (r.ex[1]) chk(io_addr_q, r.adr);
      chk(16'(flags_q), 16'(FLAGS_RST));
    end
    // Immediate refresh of the built-in terminals.
    exec(OP_LD, 1'h0, 1'h0, 16'h0000, 4'h0, SECT_RUN, 1'h1);
    exec(OP_OUT, 1'h0, 1'h1, {TERM_WORD, 4'h3}, 4'h0, SECT_RUN, 1'h0);
    chk(term_q, 16'h0008);
    exec(OP_OUT_NOT, 1'h0, 1'h1, {TERM_WORD, 4'h3}, 4'h0, SECT_RUN, 1'h0);
    chk(term_q, 16'h0000);
    exec(OP_OUT, 1'h0, 1'h0, {TERM_WORD, 4'h5}, 4'h0, SECT_RUN, 1'h0);
    chk(term_q, 16'h0000);
    exec(OP_OUT, 1'h0, 1'h1, {TERM_WORD, 4'h5}, 4'h0, SECT_RUN, 1'h0);
    chk(term_q, 16'h0020);
    // Temporary bits named by anything but OP_LD or output, OP_LD_NOT included, are refused.
    foreach (bad_ops[k]) begin
      exec(bad_ops[k], 1'h1, 1'h0, 16'h0002, 4'h0, SECT_RUN, 1'h0);
      chk({reject_q, io_we_q, cond_q, flags_q[FLAG_ERR_POS]}, 16'h000B);
    end
    idle();
    chk(16'(reject_q), 16'h0000);
    flag_clr = 1'h1;
    // A refusal in the same cycle as a clear must leave the flag set.
    exec(OP_OR, 1'h1, 1'h0, 16'h0002, 4'h0, SECT_RUN, 1'h0);
    chk(16'(flags_q[FLAG_ERR_POS]), 16'h0001);
    idle();
    flag_clr = 1'h0;
    chk(16'(flags_q), 16'h0000);
    // Reset in mid-run clears outputs, temporary bits and edge memories.
    rst_b = 1'h0;
    @(posedge sys_clk);
    #10;
    chk({cond_q, io_we_q, reject_q, flags_q}, 16'h0000);
    chk(term_q, TERM_RST);
    rst_b = 1'h1;
    repeat (3) idle();
    exec(OP_LD, 1'h1, 1'h0, 16'h0009, 4'h0, SECT_RUN, 1'h1);
    chk(16'(cond_q), 16'h0000);
    exec(OP_LD, 1'h0, 1'h0, 16'h0000, 4'h0, SECT_RUN, 1'h1);
    exec(OP_RISE, 1'h0, 1'h0, 16'h0000, 4'h0, SECT_RUN, 1'h0);
    chk(16'(cond_q), 16'h0001);
    // Save the inverse in a fresh bit, restore it at once, then build on it.
    exec(OP_OUT_NOT, 1'h1, 1'h0, 16'h0006, 4'h0, SECT_RUN, 1'h0);
    exec(OP_LD, 1'h1, 1'h0, 16'h0006, 4'h0, SECT_RUN, 1'h1);
    chk(16'(cond_q), 16'h0000);
    exec(OP_AND, 1'h0, 1'h0, 16'h0010, 4'h0, SECT_RUN, 1'h1);
    chk(16'(cond_q), 16'h0000);
    exec(OP_OR, 1'h0, 1'h0, 16'h0011, 4'h0, SECT_RUN, 1'h1);
    exec(OP_OR, 1'h0, 1'h0, 16'h0012, 4'h0, SECT_RUN, 1'h0);
    exec(OP_NOP, 1'h0, 1'h0, 16'h0000, 4'h0, SECT_RUN, 1'h0);
    chk(16'(cond_q), 16'h0001);
    idle();
    wrap_up();
  end
endmodule
`default_nettype wire
